// >>> src/bstap_cfg.svh
`ifndef BSTAP_CFG_SVH
`define BSTAP_CFG_SVH

// ----------------------------------------
// Register lengths
// ----------------------------------------
`define BSTAP_IR_LEN 10
`define BSTAP_ID_LEN 32
`define BSTAP_CELL_BITS 3
`define BSTAP_NPINS 8
`define BSTAP_BUF_DEPTH 2

// ----------------------------------------
// Instruction codes and capture values
// ----------------------------------------
`define BSTAP_OP_EXTEST 10'h00F
`define BSTAP_OP_SAMPLE 10'h005
`define BSTAP_OP_BYPASS 10'h3FF
`define BSTAP_OP_IDCODE 10'h006
`define BSTAP_OP_CLAMP 10'h00A
`define BSTAP_OP_HIGHZ 10'h00B
`define BSTAP_IR_CAPTURE 10'h001
// Identification value is arbitrary
`define BSTAP_ID_VALUE 32'h00001001

`endif

// >>> src/bstap_pkg.sv
`include "bstap_cfg.svh"

package bstap_pkg;

  // ----------------------------------------
  // Controller states and data path choice
  // ----------------------------------------
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bstap_state_e;

  typedef enum logic [1:0] {DR_BYP, DR_ID, DR_BSR} bstap_dr_e;

  // Test pins travel together through the synchroniser
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstap_pins_s;

  // One loaded instruction handed to the core
  typedef struct packed {
    logic [`BSTAP_IR_LEN-1:0] code;
  } bstap_ir_s;

endpackage : bstap_pkg

// >>> src/bstap_top.sv
`timescale 1ns/10ps
`include "bstap_cfg.svh"

module bstap_top import bstap_pkg::*; #(
  parameter int NPINS = `BSTAP_NPINS
) (
  input wire logic i_mclk, // System clock, 200 MHz
  input wire logic i_rst, // Power-up reset, sync, high
  input wire logic i_tck, // Test clock pin
  input wire logic i_tms, // Test mode select pin
  input wire logic i_tdi, // Test data in pin
  output logic o_tdo, // Test data out
  output logic o_tdo_oe_n, // Test data out enable, low drives
  input wire logic i_cfg_busy, // Configuration via test port active
  input wire logic [NPINS-1:0] i_core_out, // Core output values
  input wire logic [NPINS-1:0] i_core_oe, // Core output enables, high drives
  output logic [NPINS-1:0] o_core_in, // Pin values toward the core
  input wire logic [NPINS-1:0] i_pin_in, // User pin levels
  output logic [NPINS-1:0] o_pin_out, // User pin output values
  output logic [NPINS-1:0] o_pin_oe_n, // User pin enables, low drives
  output logic o_ir_valid, // Loaded instruction available
  output logic [`BSTAP_IR_LEN-1:0] o_ir_code, // Loaded instruction
  input wire logic i_ir_ready, // Core takes the instruction
  output logic o_tap_reset // Controller in test-logic-reset
);

  localparam int BSR_LEN = `BSTAP_CELL_BITS * NPINS;
  localparam int IRL = `BSTAP_IR_LEN;
  localparam int IDL = `BSTAP_ID_LEN;
  localparam int SW = 3 + NPINS;

  // ----------------------------------------
  // Pin synchroniser, three stages
  // ----------------------------------------
  logic [SW-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt;
  bstap_pins_s pins;
  logic [NPINS-1:0] pin_lvl;
  logic tck_rise, tck_fall;

  // A level moves only once stages two and three agree; stage one feeds stage two only
  always_comb begin
    flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      flt_r <= '0;
    end else begin
      s1_r <= {i_tck, i_tms, i_tdi, i_pin_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  assign pins = flt_r[SW-1 -: 3];
  assign pin_lvl = flt_r[NPINS-1:0];
  assign tck_rise = s2_r[SW-1] & s3_r[SW-1] & ~flt_r[SW-1];
  assign tck_fall = ~s2_r[SW-1] & ~s3_r[SW-1] & flt_r[SW-1];

  // ----------------------------------------
  // Controller and shift registers
  // ----------------------------------------
  bstap_state_e st_r, st_nxt;
  logic [IRL-1:0] ir_r, ir_nxt, irs_r, irs_nxt;
  logic [IDL-1:0] ids_r, ids_nxt;
  logic [BSR_LEN-1:0] bsr_r, bsr_nxt, upd_r, upd_nxt;
  logic byp_r, byp_nxt;
  logic adv, push, buf_in_rdy;
  bstap_dr_e sel;
  logic [BSR_LEN-1:0] cap_vec;

  // Unknown codes fall back to bypass so the chain never breaks
  function automatic bstap_dr_e dr_pick(input logic [IRL-1:0] op);
    bstap_dr_e d;
    d = DR_BYP;
    case (op)
      `BSTAP_OP_IDCODE: d = DR_ID;
      `BSTAP_OP_EXTEST, `BSTAP_OP_SAMPLE: d = DR_BSR;
      default: d = DR_BYP;
    endcase
    return d;
  endfunction : dr_pick

  assign sel = dr_pick(ir_r);

  // Per pin capture order: input, enable, output, input nearest data-out end
  for (genvar k = 0; k < NPINS; k++) begin : g_cap
    assign cap_vec[3*k] = pin_lvl[k];
    assign cap_vec[3*k+1] = i_core_oe[k];
    assign cap_vec[3*k+2] = i_core_out[k];
  end

  // Update-IR waits while the instruction buffer is full, so no code is lost
  assign adv = tck_rise & ~(st_r == UPD_IR && !buf_in_rdy);
  assign push = adv & (st_r == UPD_IR);

  always_comb begin
    st_nxt = st_r;
    ir_nxt = ir_r;
    irs_nxt = irs_r;
    ids_nxt = ids_r;
    bsr_nxt = bsr_r;
    upd_nxt = upd_r;
    byp_nxt = byp_r;
    if (adv) begin
      unique case (st_r)
        TLR: st_nxt = pins.tms ? TLR : RTI;
        RTI: st_nxt = pins.tms ? SEL_DR : RTI;
        SEL_DR: st_nxt = pins.tms ? SEL_IR : CAP_DR;
        CAP_DR: st_nxt = pins.tms ? EX1_DR : SH_DR;
        SH_DR: st_nxt = pins.tms ? EX1_DR : SH_DR;
        EX1_DR: st_nxt = pins.tms ? UPD_DR : PAU_DR;
        PAU_DR: st_nxt = pins.tms ? EX2_DR : PAU_DR;
        EX2_DR: st_nxt = pins.tms ? UPD_DR : SH_DR;
        UPD_DR: st_nxt = pins.tms ? SEL_DR : RTI;
        SEL_IR: st_nxt = pins.tms ? TLR : CAP_IR;
        CAP_IR: st_nxt = pins.tms ? EX1_IR : SH_IR;
        SH_IR: st_nxt = pins.tms ? EX1_IR : SH_IR;
        EX1_IR: st_nxt = pins.tms ? UPD_IR : PAU_IR;
        PAU_IR: st_nxt = pins.tms ? EX2_IR : PAU_IR;
        EX2_IR: st_nxt = pins.tms ? UPD_IR : SH_IR;
        UPD_IR: st_nxt = pins.tms ? SEL_DR : RTI;
      endcase
      unique case (st_r)
        TLR: ir_nxt = `BSTAP_OP_IDCODE;
        CAP_IR: irs_nxt = `BSTAP_IR_CAPTURE;
        SH_IR: irs_nxt = {pins.tdi, irs_r[IRL-1:1]};
        UPD_IR: ir_nxt = irs_r;
        CAP_DR: begin
          byp_nxt = 1'b0;
          ids_nxt = `BSTAP_ID_VALUE;
          if (sel == DR_BSR) begin
            bsr_nxt = cap_vec;
          end
        end
        SH_DR: begin
          byp_nxt = pins.tdi;
          if (sel == DR_ID) begin
            ids_nxt = {pins.tdi, ids_r[IDL-1:1]};
          end
          if (sel == DR_BSR) begin
            bsr_nxt = {pins.tdi, bsr_r[BSR_LEN-1:1]};
          end
        end
        UPD_DR: begin
          if (sel == DR_BSR) begin
            upd_nxt = bsr_r;
          end
        end
        default: begin
        end
      endcase
      // Every way into reset reloads identification, so reset never keeps an old mode
      if (st_nxt == TLR) begin
        ir_nxt = `BSTAP_OP_IDCODE;
      end
    end
  end

  // Only power-up and the mode-select walk reset the test logic; no test reset pin
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= TLR;
      ir_r <= `BSTAP_OP_IDCODE;
      irs_r <= '0;
      ids_r <= '0;
      bsr_r <= '0;
      upd_r <= '0;
      byp_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ir_r <= ir_nxt;
      irs_r <= irs_nxt;
      ids_r <= ids_nxt;
      bsr_r <= bsr_nxt;
      upd_r <= upd_nxt;
      byp_r <= byp_nxt;
    end
  end

  // ----------------------------------------
  // Test data out on falling test clock
  // ----------------------------------------
  logic tdo_r, tdo_nxt, tdo_oe_n_r, tdo_oe_n_nxt;
  logic shifting;

  assign shifting = (st_r == SH_IR) || (st_r == SH_DR);

  always_comb begin
    tdo_nxt = tdo_r;
    tdo_oe_n_nxt = tdo_oe_n_r;
    if (tck_fall) begin
      tdo_oe_n_nxt = ~shifting;
      if (st_r == SH_IR) begin
        tdo_nxt = irs_r[0];
      end else if (st_r == SH_DR) begin
        unique case (sel)
          DR_ID: tdo_nxt = ids_r[0];
          DR_BSR: tdo_nxt = bsr_r[0];
          DR_BYP: tdo_nxt = byp_r;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tdo_r <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end else begin
      tdo_r <= tdo_nxt;
      tdo_oe_n_r <= tdo_oe_n_nxt;
    end
  end

  assign o_tdo = tdo_r;
  assign o_tdo_oe_n = tdo_oe_n_r;
  assign o_tap_reset = (st_r == TLR);

  // ----------------------------------------
  // User pin control
  // ----------------------------------------
  logic ext, hiz;
  logic [NPINS-1:0] pout_r, pout_nxt, poe_n_r, poe_n_nxt, cin_r, cin_nxt;

  // Test logic leaves pins alone in reset, so normal operation continues
  assign ext = (st_r != TLR) && (ir_r == `BSTAP_OP_EXTEST || ir_r == `BSTAP_OP_CLAMP);
  assign hiz = i_cfg_busy || ((st_r != TLR) && ir_r == `BSTAP_OP_HIGHZ);

  for (genvar k = 0; k < NPINS; k++) begin : g_pin
    assign pout_nxt[k] = ext ? upd_r[3*k+2] : i_core_out[k];
    assign poe_n_nxt[k] = hiz | (ext ? ~upd_r[3*k+1] : ~i_core_oe[k]);
    assign cin_nxt[k] = ext ? upd_r[3*k] : pin_lvl[k];
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pout_r <= '0;
      poe_n_r <= '1;
      cin_r <= '0;
    end else begin
      pout_r <= pout_nxt;
      poe_n_r <= poe_n_nxt;
      cin_r <= cin_nxt;
    end
  end

  assign o_pin_out = pout_r;
  assign o_pin_oe_n = poe_n_r;
  assign o_core_in = cin_r;

  // ----------------------------------------
  // Two-entry instruction buffer toward the core
  // ----------------------------------------
  localparam int DEPTH = `BSTAP_BUF_DEPTH;
  bstap_ir_s mem_r [DEPTH];
  bstap_ir_s mem_nxt [DEPTH];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic pop;

  assign buf_in_rdy = (cnt_r != 2'(DEPTH));
  assign pop = o_ir_valid & i_ir_ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = '{code: irs_r};
      wp_nxt = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    cnt_nxt = cnt_r + 2'(push) - 2'(pop);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mem_r <= '{default: '0};
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign o_ir_valid = (cnt_r != 2'h0);
  assign o_ir_code = mem_r[rp_r].code;

endmodule : bstap_top

// >>> tb/bstap_monitor.sv
`timescale 1ns/10ps
`include "bstap_cfg.svh"
module bstap_monitor #(
  parameter int NPINS = `BSTAP_NPINS
) (
  input wire logic i_mclk, // System clock
  input wire logic i_rst, // Sync reset, high
  input wire logic i_tck, // Test clock pin
  input wire logic i_cfg_busy, // Configuration active
  input wire logic i_ir_ready, // Core takes the head instruction
  input wire logic o_tdo, // Test data out
  input wire logic o_tdo_oe_n, // Data out enable, low drives
  input wire logic [NPINS-1:0] o_pin_oe_n, // Pin enables, low drives
  input wire logic o_ir_valid, // Instruction waiting
  input wire logic [`BSTAP_IR_LEN-1:0] o_ir_code, // Head instruction
  input wire logic o_tap_reset // Controller in test-logic-reset
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Steps
  // ----------------------------------------
  sequence rst_done;
    $fell(i_rst);
  endsequence
  sequence head_held;
    o_ir_valid && !i_ir_ready;
  endsequence
  // Changes caused by reset itself are excluded through the past reset level
  chk_reset_idle: assert property (rst_done |-> o_tap_reset && o_tdo_oe_n && &o_pin_oe_n)
    else $error("port not idle after reset");
  chk_cfg_float: assert property (i_cfg_busy |=> &o_pin_oe_n)
    else $error("user pin driven during configuration");
  chk_tdo_fall: assert property ($changed(o_tdo) && !$past(i_rst) |-> !i_tck)
    else $error("data out moved while test clock high");
  chk_oe_fall: assert property ($changed(o_tdo_oe_n) && !$past(i_rst) |-> !i_tck)
    else $error("data out enable moved while test clock high");
  chk_idle_float: assert property (o_tap_reset |-> o_tdo_oe_n)
    else $error("data out driven in reset state");
  chk_move_rise: assert property ($changed(o_tap_reset) && !$past(i_rst) |-> i_tck)
    else $error("controller moved while test clock low");
  chk_head_hold: assert property (head_held |=> o_ir_valid && $stable(o_ir_code))
    else $error("instruction lost before it was taken");
  chk_push_rise: assert property ($rose(o_ir_valid) |-> i_tck)
    else $error("instruction pushed away from a test clock rise");
endmodule : bstap_monitor

// >>> tb/bstap_tester.sv
`timescale 1ns/10ps
module bstap_tester (
  input wire logic i_tdo, // Data out from the device
  input wire logic i_tdo_oe_n, // Data out enable, low drives
  output logic o_tck, // Test clock, still between frames
  output logic o_tms, // Mode select
  output logic o_tdi // Data in, rests at its pull-up level
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // One test clock: levels move at the fall so they are settled at the rise
  task automatic step(input logic m, input logic d, output logic t, output logic o);
    o_tms = m;
    o_tdi = d;
    #80;
    o_tck = 1'b1;
    // A floating data-out has no pull, so the model shows the opposite of its last level
    t = i_tdo_oe_n ? ~i_tdo : i_tdo;
    o = i_tdo_oe_n;
    #80;
    o_tck = 1'b0;
  endtask : step
  // Idle to a shift state and back to idle; bits go least significant first
  // After bit pz the walk rests in the pause state, then resumes shifting
  task automatic scan(input bit ir, input int n, input int pz, input logic [31:0] din,
      output logic [31:0] dout, output bit oe_ok);
    logic t;
    logic o;
    dout = '0;
    oe_ok = 1'b1;
    step(1'b1, 1'b1, t, o);
    if (ir) step(1'b1, 1'b1, t, o);
    step(1'b0, 1'b1, t, o);
    step(1'b0, 1'b1, t, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pz, din[i], t, o);
      dout[i] = t;
      oe_ok &= (o === 1'b0);
      if (i == pz && i < n - 1) begin
        step(1'b0, 1'b1, t, o);
        oe_ok &= (o === 1'b1);
        step(1'b0, 1'b1, t, o);
        step(1'b1, 1'b1, t, o);
        step(1'b0, 1'b1, t, o);
      end
    end
    step(1'b1, 1'b1, t, o);
    oe_ok &= (o === 1'b1);
    step(1'b0, 1'b1, t, o);
    o_tms = 1'b1;
  endtask : scan
  // Five high clocks reach reset from any state unless Update-IR stalls on a full buffer
  task automatic five_high();
    logic t;
    logic o;
    repeat (5) step(1'b1, 1'b1, t, o);
  endtask : five_high
endmodule : bstap_tester

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`include "bstap_cfg.svh"
module tb_top;
  localparam int N = `BSTAP_NPINS;
  localparam int BL = 3 * N;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_cfg_busy = 1'b0;
  logic i_ir_ready = 1'b0;
  logic [N-1:0] i_core_out = '0, i_core_oe = '0, i_pin_in = '0;
  logic tck, tms, tdi, o_tdo, o_tdo_oe_n, o_ir_valid, o_tap_reset, t, o;
  logic [N-1:0] o_core_in, o_pin_out, o_pin_oe_n;
  logic [`BSTAP_IR_LEN-1:0] o_ir_code;
  logic [`BSTAP_IR_LEN-1:0] exp_q[$];
  logic [`BSTAP_IR_LEN-1:0] codes[5];
  logic [31:0] dout, upd, d;
  bit oe_ok;
  int n_errors = 0;
  int n_checks = 0;
  bstap_top #(.NPINS(N)) uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .i_cfg_busy(i_cfg_busy),
    .i_core_out(i_core_out), .i_core_oe(i_core_oe), .o_core_in(o_core_in),
    .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
    .o_ir_valid(o_ir_valid), .o_ir_code(o_ir_code), .i_ir_ready(i_ir_ready),
    .o_tap_reset(o_tap_reset));
  bstap_tester far (.i_tdo(o_tdo), .i_tdo_oe_n(o_tdo_oe_n), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi));
  initial forever #2.5 i_mclk = ~i_mclk;
  // ----------------------------------------
  // Checking and model helpers
  // ----------------------------------------
  task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_vec
  task automatic tk(input logic m);
    far.step(m, 1'b1, t, o);
  endtask : tk
  // Boundary capture: per pin input, enable, output, pin 0 leaves first
  function automatic logic [31:0] cap_exp();
    logic [31:0] v;
    v = '0;
    for (int k = 0; k < N; k++) v[3*k +: 3] = {i_core_out[k], i_core_oe[k], i_pin_in[k]};
    return v;
  endfunction : cap_exp
  // Mode 0 normal, 1 driven from update cells, 2 floating
  task automatic pins(input int m);
    logic [N-1:0] po, pe, ci;
    for (int k = 0; k < N; k++) begin
      po[k] = (m == 1) ? upd[3*k+2] : i_core_out[k];
      pe[k] = (m == 2) ? 1'b1 : (m == 1) ? ~upd[3*k+1] : ~i_core_oe[k];
      ci[k] = (m == 1) ? upd[3*k] : i_pin_in[k];
    end
    cmp_vec(o_pin_oe_n, pe);
    if (m != 2) cmp_vec(o_pin_out, po);
    cmp_vec(o_core_in, ci);
  endtask : pins
  // The buffer model is a queue: every update pushes, the core pops in order
  task automatic pop_all();
    while (exp_q.size() > 0) begin
      cmp_vec(o_ir_valid, 1'b1);
      cmp_vec(o_ir_code, exp_q.pop_front());
      i_ir_ready = 1'b1;
      @(posedge i_mclk) #1;
    end
    i_ir_ready = 1'b0;
    cmp_vec(o_ir_valid, 1'b0);
  endtask : pop_all
  task automatic load(input logic [`BSTAP_IR_LEN-1:0] code, input bit drain);
    far.scan(1'b1, `BSTAP_IR_LEN, 4, 32'(code), dout, oe_ok);
    cmp_vec(dout, `BSTAP_IR_CAPTURE);
    cmp_vec(oe_ok, 1'b1);
    exp_q.push_back(code);
    if (drain) pop_all();
  endtask : load
  task automatic dr(input int n, input logic [31:0] din, input logic [31:0] exp);
    far.scan(1'b0, n, n / 2, din, dout, oe_ok);
    cmp_vec(dout, exp);
    cmp_vec(oe_ok, 1'b1);
  endtask : dr
  task automatic end_test(input string s);
    $display("Test %s done, errors so far %0d", s, n_errors);
  endtask : end_test
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(39));
    repeat (16) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1 cmp_vec(o_tap_reset, 1'b1);
    tk(1'b0);
    dr(32, $urandom, `BSTAP_ID_VALUE);
    end_test("power-up identification");
    load(`BSTAP_OP_BYPASS, 1'b1);
    d = $urandom;
    dr(8, d, {d[6:0], 1'b0});
    // Abort in mid-shift; the identification register must come back
    tk(1'b1);
    tk(1'b0);
    tk(1'b0);
    far.five_high();
    cmp_vec(o_tap_reset, 1'b1);
    cmp_vec(o_tdo_oe_n, 1'b1);
    tk(1'b0);
    dr(32, $urandom, `BSTAP_ID_VALUE);
    end_test("bypass and abort");
    i_pin_in = N'($urandom);
    i_core_out = N'($urandom);
    i_core_oe = N'($urandom);
    load(`BSTAP_OP_SAMPLE, 1'b1);
    upd = $urandom % (32'h1 << BL);
    dr(BL, upd, cap_exp());
    pins(0);
    end_test("sample and preload");
    codes = '{`BSTAP_OP_EXTEST, `BSTAP_OP_CLAMP, `BSTAP_OP_HIGHZ, `BSTAP_OP_BYPASS, 10'h155};
    foreach (codes[i]) begin
      load(codes[i], 1'b1);
      pins(i < 2 ? 1 : i == 2 ? 2 : 0);
      d = $urandom;
      if (i > 0) dr(8, d, {d[6:0], 1'b0});
      if (i == 0) begin
        i_cfg_busy = 1'b1;
        @(posedge i_mclk) #1 cmp_vec(o_pin_oe_n, {N{1'b1}});
        i_cfg_busy = 1'b0;
        @(posedge i_mclk) #1;
      end
    end
    end_test("instruction modes");
    // Third update stalls on a full buffer until the core takes one
    for (int i = 0; i < 3; i++) load(codes[i+1], 1'b0);
    cmp_vec(o_ir_code, exp_q.pop_front());
    i_ir_ready = 1'b1;
    @(posedge i_mclk) #1 i_ir_ready = 1'b0;
    tk(1'b0);
    pop_all();
    end_test("buffer stall");
    tally_and_finish();
  end
  initial begin
    #400000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : tb_top
bind bstap_top bstap_monitor #(.NPINS(NPINS)) u_mon (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_tck(i_tck), .i_cfg_busy(i_cfg_busy), .i_ir_ready(i_ir_ready), .o_tdo(o_tdo),
  .o_tdo_oe_n(o_tdo_oe_n), .o_pin_oe_n(o_pin_oe_n), .o_ir_valid(o_ir_valid),
  .o_ir_code(o_ir_code), .o_tap_reset(o_tap_reset));
